// file: common/adc_timing_pkg.sv
// Package with constants for the converter clock and sample timing block
package adc_timing_pkg;
    // Conversion length in conversion clock periods
    localparam int CONV_PERIODS = 12;
    localparam logic [3:0] CONV_LAST = 4'hb;
    // Field widths
    localparam int DIV_W = 6;
    localparam int SAMC_W = 5;
    localparam int TRIG_W = 3;
    localparam int CHPS_W = 2;
    localparam int SMPI_W = 4;
    // Trigger source encodings
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    // Channel count encoding for one sample-and-hold channel
    localparam logic [1:0] CHPS_ONE = 2'h0;
    // Minimum legal sample time
    localparam logic [4:0] SAMC_MIN = 5'h01;
    // Channel count decode: 00 one, 01 two, 1x four
    localparam logic [1:0] CHPS_TWO = 2'h1;
    // RC oscillator: system clock cycles per half RC period, one tick each
    localparam int RC_PERIOD_NS = 250;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RC_HALF_CYC = RC_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] RC_RELOAD = 8'(RC_HALF_CYC - 1);
    // Converter states
    typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_e;
endpackage : adc_timing_pkg

// file: core/tad_divider.sv
// Conversion clock tick generator from instruction clock or RC source
`timescale 1ns/1ps
`default_nettype none
module tad_divider #(
    parameter int DIV_W = 6
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,              // Divider runs while module on
    input wire logic rc_sel_in,           // Use RC oscillator timing
    input wire logic [DIV_W-1:0] div_in,  // Divider field value
    output logic tick_out                 // One cycle per conversion period
);
    import adc_timing_pkg::*;

    // ==========================================================
    // Half instruction cycle counter
    logic [DIV_W-1:0] half_cnt_r, half_cnt_nxt;
    logic [7:0] rc_cnt_r, rc_cnt_nxt;
    logic tick_r, tick_nxt;
    logic [DIV_W:0] half_sum; // Halves counted once this clock has passed
    logic [DIV_W:0] half_period; // Conversion period in half cycles

    // Next-state for the divider counters
    always_comb begin
        half_sum = {1'b0, half_cnt_r} + (DIV_W+1)'(2);
        half_period = {1'b0, div_in} + (DIV_W+1)'(1);
        half_cnt_nxt = half_cnt_r;
        rc_cnt_nxt = rc_cnt_r;
        tick_nxt = 1'b0;
        if (!run_in) begin
            // Restart whenever the module is switched back on
            half_cnt_nxt = '0;
            rc_cnt_nxt = '0;
        end else if (rc_sel_in) begin
            // RC source times the conversion instead
            if (rc_cnt_r == RC_RELOAD) begin
                rc_cnt_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                rc_cnt_nxt = rc_cnt_r + 8'h01;
            end
        end else begin
            // One clock is two half counts and a period is div+1 halves,
            // so even divider values alternate between two lengths
            if (half_sum >= half_period) begin
                // Keep the leftover half so the average stays exact
                half_cnt_nxt = DIV_W'(half_sum - half_period);
                tick_nxt = 1'b1;
            end else begin
                half_cnt_nxt = DIV_W'(half_sum);
            end
        end
    end

    // Register the divider state
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            half_cnt_r <= '0;
            rc_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            half_cnt_r <= half_cnt_nxt;
            rc_cnt_r <= rc_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule // tad_divider
`default_nettype wire

// file: core/adc_clock_sample_timing.sv
// Sampling and conversion sequencer for the successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
//Function
// - Conversion lasts exactly twelve conversion periods
// - Six-bit divider gives sixty-four periods
// - Period is instruction cycle times (div+1)/2
// - RC select times conversions from RC
// - Manual and automatic sampling control supported
// - Module on is active, off disables all
// - Trigger field 111 selects auto-convert mode
// - Auto-sample restarts sampling without software
// - Simultaneous bit clear samples channels sequentially
// - Channel count 00 enables one channel
// - Sample-time field counts conversion periods
// - With auto-sample, one channel converts while other acquires
// - Manual trigger: clearing sample bit converts
// - Switching off aborts, buffer keeps last
// - Sample time zero treated as invalid
module adc_clock_sample_timing #(
    parameter int DIV_W = adc_timing_pkg::DIV_W
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    // Control fields
    input wire logic MODULE_ON_IN,                 // Module on
    input wire logic RC_CLOCK_SELECT_IN,           // RC clock select
    input wire logic [DIV_W-1:0] CONV_CLOCK_DIVIDER_IN,
    input wire logic SAMPLE_CONTROL_IN,            // Software sample bit
    input wire logic [adc_timing_pkg::TRIG_W-1:0] TRIGGER_SOURCE_SELECT_IN,
    input wire logic EXT_TRIGGER_IN,               // Other trigger pulse
    input wire logic AUTO_SAMPLE_ENABLE_IN,
    input wire logic SIMULTANEOUS_SAMPLE_SELECT_IN,
    input wire logic [adc_timing_pkg::CHPS_W-1:0] SH_CHANNEL_COUNT_IN,
    input wire logic [adc_timing_pkg::SAMC_W-1:0] AUTO_SAMPLE_TIME_IN,
    // Sequencer status
    output logic CONV_TICK_OUT,                    // Conversion period tick
    output logic SAMPLING_OUT,                     // Sampling in progress
    output logic [3:0] SH_SAMPLE_EN_OUT,           // Channels acquiring
    output logic CONV_START_OUT,                   // Conversion start pulse
    output logic CONVERTING_OUT,                   // Conversion in progress
    output logic [1:0] CONV_CHANNEL_OUT,           // Channel being converted
    output logic [3:0] CONV_STEP_OUT,              // Period within conversion
    // Completion pulses
    output logic CONV_DONE_OUT,                    // Result may be stored
    output logic SAMPLE_DONE_OUT,                  // Sample bit clear request
    // Power and configuration status
    output logic ANALOG_ENABLE_OUT,                // Power analog part
    output logic SAMPLE_TIME_INVALID_OUT           // Sample time zero flag
);
    import adc_timing_pkg::*;

    // ==========================================================
    // Overview
    // The sequencer walks from off to idle, to sampling, to converting.
    // Idle waits for the sample bit or the auto-sample bit; sampling
    // keeps the chosen sample-and-hold channel acquiring until the
    // trigger; converting lasts twelve conversion periods. A cleared
    // module-on bit sends it back to off and drops unfinished work.
    // Every period count uses the divider tick, and the divider reads
    // its source and value every clock, so a change acts mid-period.

    // ==========================================================
    // Conversion clock
    // The divider only runs while the module is on, so the first tick
    // after power-on comes a whole period later. Software must still
    // let the analog part settle before it starts sampling.
    logic tick; // One cycle per conversion period

    // Divider runs only in active mode
    // Holding it while off restarts the period count, so no short
    // period can reach the converter after power-on
    tad_divider #(.DIV_W(DIV_W)) u_div (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .run_in(MODULE_ON_IN),
        .rc_sel_in(RC_CLOCK_SELECT_IN),
        .div_in(CONV_CLOCK_DIVIDER_IN),
        .tick_out(tick)
    );

    // ==========================================================
    // Sequencer state
    // Each register has its next value computed in one combinational
    // process; the clocked process copies them or loads the reset values,
    // so power-off behaviour can be read in the combinational one.
    conv_state_e state_r, state_nxt;
    logic [SAMC_W-1:0] sample_control_cnt_r, sample_control_cnt_nxt;   // Sample periods elapsed
    logic [3:0] conv_cnt_r, conv_cnt_nxt;           // Conversion periods
    logic [1:0] chan_r, chan_nxt;                   // Channel converting
    logic [1:0] seq_r, seq_nxt;                     // Channel within group
    logic sample_control_prev_r, sample_control_prev_nxt;               // Sample bit last cycle
    // One-cycle pulses
    logic start_r, start_nxt; // Conversion start
    logic done_r, done_nxt; // Conversion complete
    logic sdone_r, sdone_nxt; // Sample bit cleared by hardware
    // Decoded configuration
    logic [1:0] last_ch;                            // Highest channel index
    logic [SAMC_W-1:0] samc_eff;                    // Legal sample time
    logic trig;                                     // Conversion trigger

    // Channel count decode
    // Both codes with the upper bit set select four channels; last_ch
    // is the index at which the channel sequence wraps
    always_comb begin
        if (SH_CHANNEL_COUNT_IN == CHPS_ONE) begin
            // One channel, always channel zero
            last_ch = 2'h0;
        end else if (SH_CHANNEL_COUNT_IN == CHPS_TWO) begin
            // Two channels alternate
            last_ch = 2'h1;
        end else begin
            // Four channels in turn
            last_ch = 2'h3;
        end
    end

    // Sample time zero is replaced by the minimum
    // A zero field would trigger before any sampling period passed,
    // breaking the one-period minimum, so it acts as one
    assign samc_eff = (AUTO_SAMPLE_TIME_IN < SAMC_MIN) ? SAMC_MIN
                      : AUTO_SAMPLE_TIME_IN;

    // Trigger selection by source field
    // The manual trigger is the falling edge of the sample bit, seen as
    // one at the last edge and zero now. The automatic trigger fires on
    // the tick that completes the programmed number of sample periods.
    // All other codes take the pulse on the external trigger input.
    always_comb begin
        unique case (TRIGGER_SOURCE_SELECT_IN)
            // Falling edge of sample bit
            TRIG_MANUAL: trig = sample_control_prev_r && !SAMPLE_CONTROL_IN;
            // Sample counter reaches field at a period tick
            TRIG_AUTO: trig = tick && (sample_control_cnt_r + SAMC_W'(1) >= samc_eff);
            // Timer, motor control or pin event from outside the block
            default: trig = EXT_TRIGGER_IN;
        endcase
    end

    // Next state of the sequencer
    // Power-off is tested first so that it wins over a start in the
    // same cycle. Pulses default to zero and so last one cycle. The
    // channel index only advances when a conversion completes, and an
    // abort restarts the sequence from channel zero after power-on.
    always_comb begin
        state_nxt = state_r;
        sample_control_cnt_nxt = sample_control_cnt_r;
        conv_cnt_nxt = conv_cnt_r;
        chan_nxt = chan_r;
        seq_nxt = seq_r;
        sample_control_prev_nxt = SAMPLE_CONTROL_IN;
        start_nxt = 1'b0;
        done_nxt = 1'b0;
        sdone_nxt = 1'b0;
        if (!MODULE_ON_IN) begin
            // Off wins over any pending start; no done for partial work
            state_nxt = ST_OFF;
            // Counters restart from zero at the next power-on
            sample_control_cnt_nxt = '0;
            conv_cnt_nxt = '0;
            seq_nxt = '0;
            chan_nxt = '0;
        end else begin
            unique case (state_r)
                ST_OFF: begin
                    // Leave off mode one cycle after power-on
                    state_nxt = ST_IDLE;
                end
                ST_IDLE: begin
                    // Sampling begins by software or automatically
                    if (SAMPLE_CONTROL_IN || AUTO_SAMPLE_ENABLE_IN) begin
                        state_nxt = ST_SAMPLE;
                        sample_control_cnt_nxt = '0;
                    end
                end
                ST_SAMPLE: begin
                    // Count sample periods; trigger ends acquisition
                    if (tick) begin
                        sample_control_cnt_nxt = sample_control_cnt_r + SAMC_W'(1);
                    end
                    if (trig) begin
                        // Hand the held sample to the converter
                        state_nxt = ST_CONVERT;
                        conv_cnt_nxt = '0;
                        chan_nxt = seq_r;
                        start_nxt = 1'b1;
                        // Hardware clears the sample bit with auto-sample and a non-manual trigger
                        sdone_nxt = AUTO_SAMPLE_ENABLE_IN
                                    && (TRIGGER_SOURCE_SELECT_IN != TRIG_MANUAL);
                    end
                end
                ST_CONVERT: begin
                    // Twelve periods then result ready
                    if (tick) begin
                        if (conv_cnt_r == CONV_LAST) begin
                            // Last period over: result may be stored
                            done_nxt = 1'b1;
                            conv_cnt_nxt = '0;
                            seq_nxt = (seq_r == last_ch) ? 2'h0
                                      : seq_r + 2'h1;
                            if (AUTO_SAMPLE_ENABLE_IN) begin
                                // Next acquisition starts at once
                                state_nxt = ST_SAMPLE;
                                sample_control_cnt_nxt = '0;
                            end else begin
                                // Wait for the next software request
                                state_nxt = ST_IDLE;
                            end
                        end else begin
                            // Step to the next conversion period
                            conv_cnt_nxt = conv_cnt_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Register the sequencer
    // Reset leaves the block in off mode with every pulse low, the
    // same state that a cleared module-on bit produces
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            // Asynchronous clear to off mode
            state_r <= ST_OFF;
            sample_control_cnt_r <= '0;
            conv_cnt_r <= '0;
            chan_r <= '0;
            seq_r <= '0;
            sample_control_prev_r <= 1'b0;
            start_r <= 1'b0;
            done_r <= 1'b0;
            sdone_r <= 1'b0;
        end else begin
            // Copy the next values
            state_r <= state_nxt;
            sample_control_cnt_r <= sample_control_cnt_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            chan_r <= chan_nxt;
            seq_r <= seq_nxt;
            sample_control_prev_r <= sample_control_prev_nxt;
            start_r <= start_nxt;
            done_r <= done_nxt;
            sdone_r <= sdone_nxt;
        end
    end

    // ==========================================================
    // Sample-and-hold enables
    // Only one channel acquires at a time in sequential mode; with
    // auto-sample the next channel starts acquiring as soon as the
    // present one is handed to the converter.
    logic [3:0] sh_en;

    // Sequential with auto-sample: one channel acquires while another converts;
    // simultaneous: all enabled channels acquire together
    always_comb begin
        sh_en = 4'h0;
        if (state_r == ST_SAMPLE) begin
            if (SIMULTANEOUS_SAMPLE_SELECT_IN && last_ch != 2'h0) begin
                // All enabled channels together
                sh_en = (last_ch == 2'h1) ? 4'h3 : 4'hf;
            end else begin
                // Only the channel next in turn
                sh_en = 4'h1 << seq_r;
            end
        end else if (state_r == ST_CONVERT && AUTO_SAMPLE_ENABLE_IN
                     && last_ch != 2'h0 && !SIMULTANEOUS_SAMPLE_SELECT_IN) begin
            // Next channel already acquiring during conversion
            sh_en = 4'h1 << ((chan_r == last_ch) ? 2'h0
                             : chan_r + 2'h1);
        end
    end

    // ==========================================================
    // Outputs
    // Pulses and counts come straight from registers and the levels
    // decode the registered state; the channel enables, the analog
    // enable and the zero time flag follow the control inputs directly.
    assign CONV_TICK_OUT = tick;
    assign SAMPLING_OUT = (state_r == ST_SAMPLE);
    assign SH_SAMPLE_EN_OUT = sh_en;

    // Conversion progress
    assign CONV_START_OUT = start_r;
    assign CONVERTING_OUT = (state_r == ST_CONVERT);
    assign CONV_CHANNEL_OUT = chan_r;
    assign CONV_STEP_OUT = conv_cnt_r;
    assign CONV_DONE_OUT = done_r;
    assign SAMPLE_DONE_OUT = sdone_r;

    // Power state and field check
    assign ANALOG_ENABLE_OUT = MODULE_ON_IN;
    assign SAMPLE_TIME_INVALID_OUT = (AUTO_SAMPLE_TIME_IN == 5'h00);
endmodule // adc_clock_sample_timing
`default_nettype wire

// file: bench/adc_timing_props.sv
// Port checks for the converter clock and sample sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_timing_props
    import adc_timing_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    input wire logic MODULE_ON_IN,
    input wire logic SAMPLE_CONTROL_IN,
    input wire logic [2:0] TRIGGER_SOURCE_SELECT_IN,
    input wire logic AUTO_SAMPLE_ENABLE_IN,
    input wire logic SIMULTANEOUS_SAMPLE_SELECT_IN,
    input wire logic [1:0] SH_CHANNEL_COUNT_IN,
    input wire logic [4:0] AUTO_SAMPLE_TIME_IN,
    input wire logic CONV_TICK_OUT,
    input wire logic SAMPLING_OUT,
    input wire logic [3:0] SH_SAMPLE_EN_OUT,
    input wire logic CONV_START_OUT,
    input wire logic CONVERTING_OUT,
    input wire logic [3:0] CONV_STEP_OUT,
    input wire logic CONV_DONE_OUT,
    input wire logic ANALOG_ENABLE_OUT,
    input wire logic SAMPLE_TIME_INVALID_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    // Software ends a manual sampling interval
    sequence manual_end;
        MODULE_ON_IN && TRIGGER_SOURCE_SELECT_IN == TRIG_MANUAL
            && SAMPLING_OUT && $fell(SAMPLE_CONTROL_IN);
    endsequence
    // First cycle of a conversion
    sequence conv_begin;
        CONV_START_OUT && CONVERTING_OUT && CONV_STEP_OUT == 4'h0;
    endsequence
    power_off_a: assert property (!MODULE_ON_IN |=>
        !CONVERTING_OUT && !SAMPLING_OUT) else $error("work after off");
    analog_pwr_a: assert property (ANALOG_ENABLE_OUT == MODULE_ON_IN)
        else $error("analog enable mismatch");
    samc_zero_a: assert property (SAMPLE_TIME_INVALID_OUT ==
        (AUTO_SAMPLE_TIME_IN == 5'h00)) else $error("invalid flag wrong");
    start_pulse_a: assert property (CONV_START_OUT |->
        conv_begin ##1 !CONV_START_OUT) else $error("bad start pulse");
    step_advance_a: assert property (CONVERTING_OUT && CONV_TICK_OUT
        && MODULE_ON_IN && CONV_STEP_OUT != CONV_LAST |=>
        CONV_STEP_OUT == $past(CONV_STEP_OUT) + 4'h1)
        else $error("step did not advance");
    done_after_a: assert property (CONV_DONE_OUT |->
        $past(CONV_STEP_OUT) == CONV_LAST && $past(CONV_TICK_OUT)
        && $past(CONVERTING_OUT)) else $error("early done");
    one_channel_a: assert property (SH_CHANNEL_COUNT_IN == CHPS_ONE |->
        SH_SAMPLE_EN_OUT[3:1] == 3'h0) else $error("extra channel on");
    seq_sample_a: assert property (!SIMULTANEOUS_SAMPLE_SELECT_IN |->
        $onehot0(SH_SAMPLE_EN_OUT)) else $error("channels not sequential");
    auto_rearm_a: assert property (CONV_DONE_OUT && MODULE_ON_IN
        && AUTO_SAMPLE_ENABLE_IN |-> SAMPLING_OUT) else $error("no rearm");
    manual_conv_a: assert property (manual_end |-> ##[1:2] conv_begin)
        else $error("manual trigger ignored");
endmodule // adc_timing_props
`default_nettype wire

// file: bench/conv_far_model.sv
// Far-side converter model: counts results that are delivered
`timescale 1ns/1ps
`default_nettype none
module conv_far_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic done_in,
    output logic [7:0] done_cnt_out
);
    // A result is stored only when a conversion completes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_cnt_out <= 8'h00;
        end else if (done_in) begin
            done_cnt_out <= done_cnt_out + 8'h01;
        end
    end
endmodule // conv_far_model
`default_nettype wire

// file: bench/adc_clock_sample_timing_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_clock_sample_timing_bench;
    import adc_timing_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic on = 1'b0;
    logic rc = 1'b0;
    logic sample_control = 1'b0;
    logic auto_sample_enable = 1'b0;
    logic sim = 1'b0;
    logic ext = 1'b0;
    logic [5:0] div = 6'h29;
    logic [2:0] trig = 3'h0;
    logic [1:0] chps = 2'h0;
    logic [4:0] samc = 5'h01;
    logic tick, smp, start, conv, done, sdone, aen, inv;
    logic [3:0] sh_en, step;
    logic [1:0] ch;
    logic [7:0] done_cnt, c0;
    logic [4:0] sv [4] = '{5'h01, 5'h02, 5'h05, 5'h00};
    int err_count = 0;
    int tests_run = 0;
    int n;
    always #2 clk = ~clk;
    adc_clock_sample_timing dut (
        .CLK_IN(clk), .RST_B_IN(rst_b), .MODULE_ON_IN(on),
        .RC_CLOCK_SELECT_IN(rc), .CONV_CLOCK_DIVIDER_IN(div),
        .SAMPLE_CONTROL_IN(sample_control), .TRIGGER_SOURCE_SELECT_IN(trig),
        .EXT_TRIGGER_IN(ext), .AUTO_SAMPLE_ENABLE_IN(auto_sample_enable),
        .SIMULTANEOUS_SAMPLE_SELECT_IN(sim), .SH_CHANNEL_COUNT_IN(chps),
        .AUTO_SAMPLE_TIME_IN(samc), .CONV_TICK_OUT(tick),
        .SAMPLING_OUT(smp), .SH_SAMPLE_EN_OUT(sh_en),
        .CONV_START_OUT(start), .CONVERTING_OUT(conv),
        .CONV_CHANNEL_OUT(ch), .CONV_STEP_OUT(step), .CONV_DONE_OUT(done),
        .SAMPLE_DONE_OUT(sdone), .ANALOG_ENABLE_OUT(aen),
        .SAMPLE_TIME_INVALID_OUT(inv)
    );
    conv_far_model far (.clk_in(clk), .rst_b_in(rst_b), .done_in(done),
        .done_cnt_out(done_cnt));
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bail();
        err_count++;
        $display("unexpected wait limit exp 0 got 1");
        end_of_test();
    endtask
    // Power back on after the caller switched off and set fields
    task automatic restart();
        repeat (3) @(negedge clk);
        on = 1'b1;
    endtask
    // Count ticks while converting (1) or sampling (0) stays high
    task automatic span(input logic which);
        int k;
        n = 0;
        k = 0;
        while ((which ? conv : smp) === 1'b1) begin
            n += int'(tick);
            k++;
            if (k > 600) bail();
            @(negedge clk);
        end
    endtask
    task automatic wait_start(input int lim);
        int k;
        k = 0;
        @(negedge clk);
        while (start !== 1'b1) begin
            k++;
            if (k > lim) bail();
            @(negedge clk);
        end
    endtask
    // Tick count over a window whose length is whole periods
    task automatic rate(input logic r, input logic [5:0] d, input int cyc,
                        input int exp);
        on = 1'b0;
        rc = r;
        div = d;
        restart();
        repeat (4) @(negedge clk);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            n += int'(tick);
        end
        chk("tick count", 8'(exp), 8'(n));
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("converting", 8'h00, 8'(conv));
        chk("channel enables", 8'h00, 8'(sh_en));
        $display("test reset done");
        rate(1'b0, 6'h29, 420, 20);
        rate(1'b0, 6'h2a, 430, 20);
        rate(1'b1, 6'h29, 310, 10);
        $display("test clock done");
        foreach (sv[i]) begin
            on = 1'b0;
            rc = 1'b0;
            trig = TRIG_AUTO;
            auto_sample_enable = 1'b1;
            samc = sv[i];
            restart();
            wait_start(600);
            chk("channel", 8'h00, 8'(ch));
            span(1'b1);
            chk("conv ticks", 8'(CONV_PERIODS), 8'(n));
            chk("done", 8'h01, 8'(done));
            span(1'b0);
            chk("sample ticks", (samc == 5'h00) ? 8'h01 : 8'(samc), 8'(n));
            chk("restart", 8'h01, 8'(start));
            chk("sample done", 8'h01, 8'(sdone));
            chk("invalid", 8'(samc == 5'h00), 8'(inv));
        end
        $display("test auto done");
        on = 1'b0;
        chps = CHPS_TWO;
        samc = 5'h02;
        restart();
        wait_start(600);
        for (int i = 0; i < 3; i++) begin
            c0 = 8'(ch);
            wait_start(600);
            chk("channel", c0 ^ 8'h01, 8'(ch));
        end
        $display("test channels done");
        on = 1'b0;
        chps = CHPS_ONE;
        trig = 3'h1;
        restart();
        repeat (30) @(negedge clk);
        chk("sampling", 8'h01, 8'(smp));
        ext = 1'b1;
        wait_start(3);
        ext = 1'b0;
        chk("converting", 8'h01, 8'(conv));
        chk("sample done", 8'h01, 8'(sdone));
        $display("test external done");
        on = 1'b0;
        chps = CHPS_ONE;
        trig = TRIG_MANUAL;
        auto_sample_enable = 1'b0;
        restart();
        repeat (30) @(negedge clk);
        sample_control = 1'b1;
        repeat (30) @(negedge clk);
        chk("sampling", 8'h01, 8'(smp));
        sample_control = 1'b0;
        wait_start(3);
        chk("converting", 8'h01, 8'(conv));
        chk("sample done", 8'h00, 8'(sdone));
        $display("test manual done");
        repeat (5) @(negedge clk);
        c0 = done_cnt;
        on = 1'b0;
        @(negedge clk);
        chk("converting", 8'h00, 8'(conv));
        chk("analog enable", 8'h00, 8'(aen));
        repeat (300) @(negedge clk);
        chk("results", c0, done_cnt);
        $display("test abort done");
        end_of_test();
    end
endmodule // adc_clock_sample_timing_bench
bind adc_clock_sample_timing adc_timing_props props (
    .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .MODULE_ON_IN(MODULE_ON_IN),
    .SAMPLE_CONTROL_IN(SAMPLE_CONTROL_IN),
    .TRIGGER_SOURCE_SELECT_IN(TRIGGER_SOURCE_SELECT_IN),
    .AUTO_SAMPLE_ENABLE_IN(AUTO_SAMPLE_ENABLE_IN),
    .SIMULTANEOUS_SAMPLE_SELECT_IN(SIMULTANEOUS_SAMPLE_SELECT_IN),
    .SH_CHANNEL_COUNT_IN(SH_CHANNEL_COUNT_IN),
    .AUTO_SAMPLE_TIME_IN(AUTO_SAMPLE_TIME_IN), .CONV_TICK_OUT(CONV_TICK_OUT),
    .SAMPLING_OUT(SAMPLING_OUT), .SH_SAMPLE_EN_OUT(SH_SAMPLE_EN_OUT),
    .CONV_START_OUT(CONV_START_OUT), .CONVERTING_OUT(CONVERTING_OUT),
    .CONV_STEP_OUT(CONV_STEP_OUT), .CONV_DONE_OUT(CONV_DONE_OUT),
    .ANALOG_ENABLE_OUT(ANALOG_ENABLE_OUT),
    .SAMPLE_TIME_INVALID_OUT(SAMPLE_TIME_INVALID_OUT));
`default_nettype wire
